// >>> wdrg_pkg.sv
package wdrg_pkg;
    // Register map, byte addresses on the parallel memory bus
    localparam logic [18:0] ADDR_EVENT_FLAGS = 19'h7fff0;
    localparam logic [18:0] ADDR_WATCHDOG_CONTROL = 19'h7fff7;
    localparam logic [18:0] ADDR_DAY_FT = 19'h7fffc;
    // Field positions
    localparam int FLAG_EXPIRED_BIT = 7;
    localparam int WD_ROUTE_BIT = 7;
    localparam int FT_BIT = 6;
    // Reset values
    localparam logic [7:0] WD_CONTROL_RESET = 8'h00;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int RST_PULSE_MIN_MS = 40;
    localparam int RST_PULSE_MAX_MS = 200;
    localparam int RST_PULSE_MS = RST_PULSE_MIN_MS + ((RST_PULSE_MAX_MS - RST_PULSE_MIN_MS) / 4);
    localparam int RST_PULSE_CYCLES = RST_PULSE_MS * CLK_MHZ * 1000;
    localparam int EXTERNAL_RESET_REQUEST_MIN_NS = 100;
    localparam int EXTERNAL_RESET_REQUEST_MIN_CYCLES = (EXTERNAL_RESET_REQUEST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int WD_TICK_HZ = 16;
    localparam int WD_TICK_CYCLES = (CLK_MHZ * 1000000) / WD_TICK_HZ;
    localparam int FT_HZ = 512;
    localparam int FT_HALF_CYCLES = (CLK_MHZ * 1000000) / (2 * FT_HZ);

    typedef struct packed {
        logic [18:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdrg_bus_t;
endpackage

// >>> wdrg_reset_stretch.sv
`timescale 1ns/100ps
`default_nettype none
module wdrg_reset_stretch #(
    parameter int PULSE_CYCLES = wdrg_pkg::RST_PULSE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic trigger,
    output logic active
);
    logic [31:0] count;
    logic [31:0] next_count;

    always_comb begin
        next_count = count;
        if (trigger) begin
            next_count = PULSE_CYCLES[31:0];
        end else if (count != 32'h0) begin
            next_count = count - 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            count <= PULSE_CYCLES[31:0];
        end else begin
            count <= next_count;
        end
    end

    assign active = (count != 32'h0);
endmodule
`default_nettype wire

// >>> wdrg_top.sv
// Overview of operation
// - Expiry sets flag and, on the same edge, interrupt or reset.
// - Flag is bit 7; flags read clears.
// - Route zero: timeout asserts interrupt pin.
// - Route one: 40-200 ms low reset pulse.
// - After reset timeout clear watchdog and test.
// - Any kick input edge restarts count.
// - Watchdog register write restarts count.
// - Writing zero releases interrupt, disables watchdog.
// - Power-down disables and clears watchdog.
// - Watchdog interrupt overrides frequency test output.
// - Power fail holds reset low 40-200 ms.
// - External request gives power-cycle-length reset.
// - Too-short external request pulses ignored.
// - Watchdog holds route, multiplier, resolution.
`timescale 1ns/100ps
`default_nettype none
module wdrg_top #(
    parameter int RST_PULSE_CYCLES = wdrg_pkg::RST_PULSE_CYCLES,
    parameter int TICK_CYCLES = wdrg_pkg::WD_TICK_CYCLES,
    parameter int EXTERNAL_RESET_REQUEST_MIN_CYCLES = wdrg_pkg::EXTERNAL_RESET_REQUEST_MIN_CYCLES,
    parameter int FT_DIV_CYCLES = wdrg_pkg::FT_HALF_CYCLES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire wdrg_pkg::wdrg_bus_t bus,
    output logic [7:0] rdata,
    input wire logic kick_input,
    input wire logic external_reset_request_n,
    input wire logic power_fail_threshold,
    output logic reset_out_oe,
    output logic irq_freqtest_out_oe,
    output logic [7:0] watchdog_control,
    output logic watchdog_expired_flag
);
    logic [1:0] kick_sync;
    logic kick_prev;
    logic [1:0] external_reset_request_sync;
    logic [1:0] pf_sync;
    logic [7:0] next_wd;
    logic next_flag;
    logic freq_test_enable;
    logic next_ft;
    logic wd_irq;
    logic next_wd_irq;
    logic [31:0] prescale;
    logic [31:0] next_prescale;
    logic [10:0] ticks;
    logic [10:0] next_ticks;
    logic [31:0] external_reset_request_cnt;
    logic [31:0] next_external_reset_request_cnt;
    logic [31:0] ft_cnt;
    logic [31:0] next_ft_cnt;
    logic ft_wave;
    logic next_ft_wave;
    logic next_reset_out_oe;
    logic next_irq_oe;
    logic [7:0] next_rdata;
    logic kick_edge;
    logic wr_wd;
    logic timeout;
    logic rst_trigger;
    logic rst_active;
    logic [10:0] period_ticks;

    assign kick_edge = kick_sync[1] ^ kick_prev;
    assign wr_wd = bus.wr && (bus.addr == wdrg_pkg::ADDR_WATCHDOG_CONTROL);
    // Period in ticks of 1/16 s: multiplier scaled by resolution
    // Widest period is 31 << 6 ticks, so eleven bits
    assign period_ticks = {6'h00, watchdog_control[6:2]} << {watchdog_control[1:0], 1'b0};
    assign timeout = (watchdog_control[6:2] != 5'h0) && !wd_irq && !wr_wd && !kick_edge
        && (ticks >= period_ticks) && (period_ticks != 11'h0);
    assign rst_trigger = (timeout && watchdog_control[wdrg_pkg::WD_ROUTE_BIT])
        || pf_sync[1]
        || (external_reset_request_cnt == EXTERNAL_RESET_REQUEST_MIN_CYCLES[31:0]);

    wdrg_reset_stretch #(
        .PULSE_CYCLES(RST_PULSE_CYCLES)
    ) u_stretch (
        .clk_sys(clk_sys),
        .srst(srst),
        .trigger(rst_trigger),
        .active(rst_active)
    );

    always_comb begin
        next_wd = watchdog_control;
        next_ft = freq_test_enable;
        next_wd_irq = wd_irq;
        next_flag = watchdog_expired_flag;
        next_prescale = prescale + 32'h1;
        next_ticks = ticks;
        next_rdata = 8'h00;
        if (prescale >= TICK_CYCLES[31:0] - 32'h1) begin
            next_prescale = 32'h0;
            if (ticks != 11'h7ff) begin
                next_ticks = ticks + 11'h1;
            end
        end
        if (bus.rd && bus.addr == wdrg_pkg::ADDR_EVENT_FLAGS) begin
            next_rdata = {watchdog_expired_flag, 7'h00};
            next_flag = 1'b0;
        end
        if (bus.rd && bus.addr == wdrg_pkg::ADDR_WATCHDOG_CONTROL) begin
            next_rdata = watchdog_control;
        end
        if (bus.rd && bus.addr == wdrg_pkg::ADDR_DAY_FT) begin
            next_rdata = {1'b0, freq_test_enable, 6'h00};
        end
        if (bus.wr && bus.addr == wdrg_pkg::ADDR_DAY_FT) begin
            next_ft = bus.wdata[wdrg_pkg::FT_BIT];
        end
        if (kick_edge || wr_wd) begin
            next_ticks = 11'h0;
            next_prescale = 32'h0;
        end
        if (wr_wd) begin
            next_wd = bus.wdata;
            if (bus.wdata == 8'h00) begin
                next_wd_irq = 1'b0;
            end
        end
        if (timeout) begin
            next_flag = 1'b1;
            next_ticks = 11'h0;
            if (watchdog_control[wdrg_pkg::WD_ROUTE_BIT]) begin
                next_wd = wdrg_pkg::WD_CONTROL_RESET;
                next_ft = 1'b0;
            end else begin
                next_wd_irq = 1'b1;
            end
        end
        if (pf_sync[1]) begin
            next_wd = wdrg_pkg::WD_CONTROL_RESET;
            next_wd_irq = 1'b0;
        end
        next_ft_cnt = ft_cnt + 32'h1;
        next_ft_wave = ft_wave;
        if (ft_cnt >= FT_DIV_CYCLES[31:0] - 32'h1) begin
            next_ft_cnt = 32'h0;
            next_ft_wave = !ft_wave;
        end
        next_reset_out_oe = rst_active || rst_trigger;
        // Watchdog interrupt wins over the test square wave
        next_irq_oe = next_wd_irq
            || (next_ft && (next_wd[wdrg_pkg::WD_ROUTE_BIT] || next_wd == 8'h00) && ft_wave);
    end

    always_comb begin
        next_external_reset_request_cnt = 32'h0;
        if (!external_reset_request_sync[1] && external_reset_request_cnt <= EXTERNAL_RESET_REQUEST_MIN_CYCLES[31:0]) begin
            next_external_reset_request_cnt = external_reset_request_cnt + 32'h1;
        end else if (!external_reset_request_sync[1]) begin
            next_external_reset_request_cnt = external_reset_request_cnt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            kick_sync <= 2'b00;
            kick_prev <= 1'b0;
            external_reset_request_sync <= 2'b11;
            pf_sync <= 2'b00;
            watchdog_control <= wdrg_pkg::WD_CONTROL_RESET;
            watchdog_expired_flag <= 1'b0;
            freq_test_enable <= 1'b0;
            wd_irq <= 1'b0;
            prescale <= 32'h0;
            ticks <= 11'h0;
            external_reset_request_cnt <= 32'h0;
            rdata <= 8'h00;
            ft_cnt <= 32'h0;
            ft_wave <= 1'b0;
            reset_out_oe <= 1'b1;
            irq_freqtest_out_oe <= 1'b0;
        end else begin
            kick_sync <= {kick_sync[0], kick_input};
            kick_prev <= kick_sync[1];
            external_reset_request_sync <= {external_reset_request_sync[0], external_reset_request_n};
            pf_sync <= {pf_sync[0], power_fail_threshold};
            watchdog_control <= next_wd;
            watchdog_expired_flag <= next_flag;
            freq_test_enable <= next_ft;
            wd_irq <= next_wd_irq;
            prescale <= next_prescale;
            ticks <= next_ticks;
            external_reset_request_cnt <= next_external_reset_request_cnt;
            rdata <= next_rdata;
            ft_cnt <= next_ft_cnt;
            ft_wave <= next_ft_wave;
            reset_out_oe <= next_reset_out_oe;
            irq_freqtest_out_oe <= next_irq_oe;
        end
    end

    AST_IRQ_ON_TIMEOUT: assert property (@(posedge clk_sys) disable iff (srst)
        timeout && !watchdog_control[7] && !pf_sync[1] |=> irq_freqtest_out_oe)
        else $error("interrupt not asserted on timeout");
    AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (srst)
        timeout |=> watchdog_expired_flag)
        else $error("expired flag not set");
    AST_FLAG_READ_CLEAR: assert property (@(posedge clk_sys) disable iff (srst)
        bus.rd && bus.addr == wdrg_pkg::ADDR_EVENT_FLAGS && !timeout |=> !watchdog_expired_flag)
        else $error("flag not cleared by read");
    AST_RST_ON_TIMEOUT: assert property (@(posedge clk_sys) disable iff (srst)
        timeout && watchdog_control[7] |=> reset_out_oe && watchdog_control == 8'h00 && !freq_test_enable)
        else $error("reset route timeout wrong");
    AST_KICK_RESTART: assert property (@(posedge clk_sys) disable iff (srst)
        kick_edge |=> ticks == 11'h0)
        else $error("kick did not restart");
    AST_WRITE_ZERO: assert property (@(posedge clk_sys) disable iff (srst)
        wr_wd && bus.wdata == 8'h00 && !pf_sync[1] && !freq_test_enable
        |=> !wd_irq && !irq_freqtest_out_oe)
        else $error("zero write did not release irq");
    AST_POWER_DOWN: assert property (@(posedge clk_sys) disable iff (srst)
        pf_sync[1] |=> watchdog_control == 8'h00 && reset_out_oe)
        else $error("power down handling wrong");
    AST_ZERO_STOPPED: assert property (@(posedge clk_sys) disable iff (srst)
        watchdog_control == 8'h00 |=> !$rose(watchdog_expired_flag) && !$rose(wd_irq))
        else $error("timeout while disabled");
    AST_SHORT_EXTERNAL_RESET_REQUEST: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(external_reset_request_sync[1]) && external_reset_request_cnt < EXTERNAL_RESET_REQUEST_MIN_CYCLES[31:0] |=> external_reset_request_cnt == 32'h0)
        else $error("short pulse counted");
endmodule
`default_nettype wire

// >>> wdrg_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module wdrg_host_model (
    input wire logic clk_sys,
    input wire logic reset_out_oe,
    input wire logic irq_freqtest_out_oe,
    input wire logic kick_toggle,
    output logic kick_input,
    output logic reset_pin,
    output logic irq_pin
);
    // Open-drain pins seen through pull-ups
    assign reset_pin = !reset_out_oe;
    assign irq_pin = !irq_freqtest_out_oe;
    logic kick_level = 1'b0;
    assign kick_input = kick_level;
    always @(posedge clk_sys) begin
        if (kick_toggle) begin
            kick_level <= !kick_level;
        end
    end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int PULSE = 20;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    wdrg_pkg::wdrg_bus_t bus = '0;
    logic ext_n = 1'b1;
    logic pfail = 1'b0;
    logic kick_toggle = 1'b0;
    logic [7:0] rdata;
    logic [7:0] wd_ctl;
    logic [7:0] d;
    logic kick_input, reset_out_oe, irq_oe, wd_flag, reset_pin, irq_pin;
    int fails = 0;
    int checks = 0;
    int n;
    always #2.5 clk_sys = !clk_sys;
    wdrg_top #(.RST_PULSE_CYCLES(PULSE), .TICK_CYCLES(4), .EXTERNAL_RESET_REQUEST_MIN_CYCLES(20), .FT_DIV_CYCLES(4)) dut (
        .clk_sys(clk_sys), .srst(srst), .bus(bus), .rdata(rdata), .kick_input(kick_input),
        .external_reset_request_n(ext_n), .power_fail_threshold(pfail), .reset_out_oe(reset_out_oe),
        .irq_freqtest_out_oe(irq_oe), .watchdog_control(wd_ctl), .watchdog_expired_flag(wd_flag));
    wdrg_host_model host (.clk_sys(clk_sys), .reset_out_oe(reset_out_oe), .irq_freqtest_out_oe(irq_oe),
        .kick_toggle(kick_toggle), .kick_input(kick_input), .reset_pin(reset_pin), .irq_pin(irq_pin));
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [18:0] a, input logic [7:0] v);
        bus.addr = a;
        bus.wdata = v;
        bus.wr = 1'b1;
        cyc(1);
        bus.wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [18:0] a);
        bus.addr = a;
        bus.rd = 1'b1;
        cyc(1);
        bus.rd = 1'b0;
        d = rdata;
        cyc(1);
    endtask
    // Bounded wait on reset (0), irq (1) or flag (2)
    task automatic wait_for(input int s, input logic v, input int lim);
        n = 0;
        while (((s == 0) ? reset_out_oe : (s == 1) ? irq_oe : wd_flag) !== v) begin
            cyc(1);
            n++;
            if (n > lim) begin
                fails++;
                $display("unexpected wait %0d expected %b seen timeout", s, v);
                complete_run();
            end
        end
    endtask
    // Collects which irq levels appear over k cycles
    task automatic samp(input int k);
        d = 8'h00;
        repeat (k) begin
            cyc(1);
            d = d | ((irq_oe === 1'b1) ? 8'h02 : 8'h01);
        end
    endtask
    task automatic t_irq();
        wr(wdrg_pkg::ADDR_DAY_FT, 8'h40);
        samp(20);
        chk("ft toggles", 8'h03, d);
        wr(wdrg_pkg::ADDR_WATCHDOG_CONTROL, 8'h05);
        chk("wd value", 8'h05, wd_ctl);
        samp(8);
        chk("ft denied", 8'h01, d);
        wait_for(2, 1'b1, 40);
        cyc(1);
        chk("irq", 8'h01, irq_oe);
        chk("irq pin", 8'h00, irq_pin);
        chk("no reset", 8'h00, reset_out_oe);
        rd(wdrg_pkg::ADDR_EVENT_FLAGS);
        chk("flag read", 8'h80, d & 8'h80);
        cyc(2);
        chk("flag cleared", 8'h00, wd_flag);
        wr(wdrg_pkg::ADDR_DAY_FT, 8'h00);
        wr(wdrg_pkg::ADDR_WATCHDOG_CONTROL, 8'h00);
        cyc(2);
        chk("irq released", 8'h00, irq_oe);
        cyc(60);
        chk("stopped", 8'h00, wd_flag);
        $display("t_irq done");
    endtask
    task automatic t_kick();
        wr(wdrg_pkg::ADDR_WATCHDOG_CONTROL, 8'h05);
        repeat (6) begin
            cyc(6);
            kick_toggle = 1'b1;
            cyc(1);
            kick_toggle = 1'b0;
        end
        chk("kicked", 8'h00, wd_flag);
        repeat (4) begin
            cyc(10);
            wr(wdrg_pkg::ADDR_WATCHDOG_CONTROL, 8'h05);
        end
        chk("rewritten", 8'h00, wd_flag);
        wr(wdrg_pkg::ADDR_WATCHDOG_CONTROL, 8'h00);
        $display("t_kick done");
    endtask
    task automatic t_reset();
        wr(wdrg_pkg::ADDR_DAY_FT, 8'h40);
        wr(wdrg_pkg::ADDR_WATCHDOG_CONTROL, 8'h85);
        wait_for(0, 1'b1, 40);
        chk("reset pin", 8'h00, reset_pin);
        wait_for(0, 1'b0, PULSE + 10);
        chk("pulse long", 8'h01, (n >= PULSE - 2));
        chk("wd cleared", 8'h00, wd_ctl);
        chk("flag set", 8'h01, wd_flag);
        rd(wdrg_pkg::ADDR_DAY_FT);
        chk("ft cleared", 8'h00, d & 8'h40);
        rd(wdrg_pkg::ADDR_EVENT_FLAGS);
        $display("t_reset done");
    endtask
    task automatic t_ext();
        ext_n = 1'b0;
        cyc(5);
        ext_n = 1'b1;
        cyc(10);
        chk("short ignored", 8'h00, reset_out_oe);
        ext_n = 1'b0;
        cyc(30);
        ext_n = 1'b1;
        cyc(3);
        chk("ext reset", 8'h01, reset_out_oe);
        wait_for(0, 1'b0, PULSE + 40);
        chk("ext pulse", 8'h01, (n >= PULSE / 2));
        $display("t_ext done");
    endtask
    task automatic t_pfail();
        wr(wdrg_pkg::ADDR_WATCHDOG_CONTROL, 8'h05);
        pfail = 1'b1;
        cyc(4);
        chk("pf reset", 8'h01, reset_out_oe);
        chk("pf wd clear", 8'h00, wd_ctl);
        cyc(40);
        chk("pf no flag", 8'h00, wd_flag);
        pfail = 1'b0;
        cyc(PULSE / 2);
        chk("pf hold", 8'h01, reset_out_oe);
        wait_for(0, 1'b0, PULSE + 10);
        $display("t_pfail done");
    endtask
    initial begin
        cyc(2);
        srst = 1'b0;
        wait_for(0, 1'b0, PULSE + 10);
        t_irq();
        t_kick();
        t_reset();
        t_ext();
        t_pfail();
        complete_run();
    end
endmodule
`default_nettype wire
